// file: shared/actb_pkg.sv
`default_nettype none
package actb_pkg;

	// ----------------------------------------------------------------
	// Register indices, byte address is four times the index
	// ----------------------------------------------------------------
	localparam logic [9:0]  IDX_C1_OFS  = 10'h332;
	localparam logic [9:0]  IDX_C2A_OFS = 10'h334;
	localparam logic [9:0]  IDX_C2B_OFS = 10'h336;
	localparam logic [9:0]  IDX_C3C_OFS = 10'h338;
	localparam logic [9:0]  IDX_C3D_OFS = 10'h33a;
	localparam logic [9:0]  IDX_C4_OFS  = 10'h33c;
	localparam logic [9:0]  IDX_C5_OFS  = 10'h33e;
	localparam logic [9:0]  IDX_G0_GAIN = 10'h360;
	localparam logic [9:0]  IDX_G1_GAIN = 10'h361;

	// ----------------------------------------------------------------
	// Storage slots, fuse words use the same numbering
	// ----------------------------------------------------------------
	localparam int          NUM_SLOTS   = 9;
	localparam logic [3:0]  SLOT_C1     = 4'h0;
	localparam logic [3:0]  SLOT_C2A    = 4'h1;
	localparam logic [3:0]  SLOT_C2B    = 4'h2;
	localparam logic [3:0]  SLOT_C3C    = 4'h3;
	localparam logic [3:0]  SLOT_C3D    = 4'h4;
	localparam logic [3:0]  SLOT_C4     = 4'h5;
	localparam logic [3:0]  SLOT_C5     = 4'h6;
	localparam logic [3:0]  SLOT_G0     = 4'h7;
	localparam logic [3:0]  SLOT_G1     = 4'h8;
	localparam logic [3:0]  SLOT_LAST   = 4'h8;

	// ----------------------------------------------------------------
	// Field layout and reset values
	// ----------------------------------------------------------------
	localparam int          OFS_MSB     = 11;
	localparam int          GAIN_MSB    = 4;
	localparam logic [15:0] TRIM_RST    = 16'h0000;
	localparam logic [31:0] RDATA_RST   = 32'h0000_0000;

	typedef logic [11:0] actb_ofs_t;
	typedef logic [4:0]  actb_gain_t;
	typedef logic [15:0] actb_word_t;

	typedef enum logic [1:0] {
		LD_REQ,
		LD_WAIT,
		LD_TAKE,
		LD_DONE
	} actb_ld_state_t;

	// Address decode: bit 4 is the hit flag, bits 3:0 the slot
	function automatic logic [4:0] actb_decode(input logic [11:0] addr);
		logic [4:0] r;
		r = 5'h00;
		if (addr[1:0] == 2'h0) begin
			unique case (addr[11:2])
				IDX_C1_OFS:  r = {1'b1, SLOT_C1};
				IDX_C2A_OFS: r = {1'b1, SLOT_C2A};
				IDX_C2B_OFS: r = {1'b1, SLOT_C2B};
				IDX_C3C_OFS: r = {1'b1, SLOT_C3C};
				IDX_C3D_OFS: r = {1'b1, SLOT_C3D};
				IDX_C4_OFS:  r = {1'b1, SLOT_C4};
				IDX_C5_OFS:  r = {1'b1, SLOT_C5};
				IDX_G0_GAIN: r = {1'b1, SLOT_G0};
				IDX_G1_GAIN: r = {1'b1, SLOT_G1};
				default:     r = 5'h00;
			endcase
		end
		return r;
	endfunction

endpackage
`default_nettype wire

// file: shared/actb_fuse_if.sv
`timescale 1ns/1ps
`default_nettype none
// Fuse words travelling from the loader into the trim storage
interface actb_fuse_if;
	logic        load_vld;
	logic [3:0]  load_slot;
	logic [15:0] load_data;
	logic        busy;
	modport loader (output load_vld, output load_slot, output load_data, output busy);
	modport bank   (input load_vld, input load_slot, input load_data, input busy);
endinterface
`default_nettype wire

// file: core/actb_fuse_loader.sv
`timescale 1ns/1ps
`default_nettype none
module actb_fuse_loader (
	input  wire logic        i_clk_sys,
	input  wire logic        i_sys_rst,
	input  wire logic [15:0] i_fuse_data,
	output logic      [3:0]  o_fuse_addr,
	output logic             o_fuse_rd,
	actb_fuse_if.loader      f
);
	import actb_pkg::*;

	actb_ld_state_t state_q, state_d;
	logic [3:0]     slot_q, slot_d;
	logic [3:0]     addr_q, addr_d;
	logic           rd_q, rd_d;

	// ----------------------------------------------------------------
	// Walk every fuse word once after reset
	// ----------------------------------------------------------------
	// Next state: request, wait one cycle for the fuse, then take it
	always_comb begin
		state_d = state_q;
		slot_d  = slot_q;
		addr_d  = addr_q;
		rd_d    = 1'b0;
		unique case (state_q)
			LD_REQ: begin
				rd_d    = 1'b1;
				addr_d  = slot_q;
				state_d = LD_WAIT;
			end
			LD_WAIT: begin
				state_d = LD_TAKE;
			end
			LD_TAKE: begin
				if (slot_q == SLOT_LAST) begin
					state_d = LD_DONE;
				end else begin
					slot_d  = slot_q + 4'h1;
					state_d = LD_REQ;
				end
			end
			LD_DONE: begin
				state_d = LD_DONE;
			end
		endcase
	end

	// Registers only
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_q <= LD_REQ;
			slot_q  <= 4'h0;
			addr_q  <= 4'h0;
			rd_q    <= 1'b0;
		end else begin
			state_q <= state_d;
			slot_q  <= slot_d;
			addr_q  <= addr_d;
			rd_q    <= rd_d;
		end
	end

	// Fuse data is valid in the take cycle, passed straight on
	assign f.load_vld  = (state_q == LD_TAKE);
	assign f.load_slot = slot_q;
	assign f.load_data = i_fuse_data;
	assign f.busy      = (state_q != LD_DONE);
	assign o_fuse_addr = addr_q;
	assign o_fuse_rd   = rd_q;

endmodule
`default_nettype wire

// file: core/actb_input_sel.sv
`timescale 1ns/1ps
`default_nettype none
module actb_input_sel (
	input  wire logic               i_clk_sys,
	input  wire logic               i_sys_rst,
	input  wire actb_pkg::actb_ofs_t i_ofs_a,
	input  wire actb_pkg::actb_ofs_t i_ofs_b,
	input  wire actb_pkg::actb_ofs_t i_ofs_c,
	input  wire actb_pkg::actb_ofs_t i_ofs_d,
	input  wire logic               i_core2_sel_b,
	input  wire logic               i_core3_sel_d,
	output actb_pkg::actb_ofs_t     o_core2_ofs,
	output actb_pkg::actb_ofs_t     o_core3_ofs
);
	import actb_pkg::*;

	actb_ofs_t c2_q, c2_d;
	actb_ofs_t c3_q, c3_d;

	// ----------------------------------------------------------------
	// Per-input offset follows the input being sampled
	// ----------------------------------------------------------------
	// (RULE2) core 2 input pick
	// (RULE3) core 3 input pick
	always_comb begin
		c2_d = i_core2_sel_b ? i_ofs_b : i_ofs_a;
		c3_d = i_core3_sel_d ? i_ofs_d : i_ofs_c;
	end

	// Registered so the applied value never glitches on a switch
	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			c2_q <= 12'h000;
			c3_q <= 12'h000;
		end else begin
			c2_q <= c2_d;
			c3_q <= c3_d;
		end
	end

	assign o_core2_ofs = c2_q;
	assign o_core3_ofs = c3_q;

endmodule
`default_nettype wire

// file: core/actb_trim_bank.sv
// How it works
// (RULE1) Core 1 uses its offset bits 11:0
// (RULE2) Core 2 offset follows input A or B
// (RULE3) Core 3 offset follows input C or D
// (RULE4) Core 4 uses its stored offset
// (RULE5) Core 5 uses its stored offset
// (RULE6) Core 0 gain is bits 4:0
// (RULE7) Core 1 gain has its own register
// (RULE8) Software writes zero to reserved bits
// (RULE9) Values load from fuse storage after reset
// (RULE10) Offset values are unsigned
// (RULE11) Software avoids offsets during offset calibration
// (RULE12) Reads return last write or fuse value
`timescale 1ns/1ps
`default_nettype none
module actb_trim_bank (
	input  wire logic                i_clk_sys,
	input  wire logic                i_sys_rst,
	input  wire logic                i_psel,
	input  wire logic                i_penable,
	input  wire logic                i_pwrite,
	input  wire logic [11:0]         i_paddr,
	input  wire logic [31:0]         i_pwdata,
	output logic      [31:0]         o_prdata,
	output logic                     o_pready,
	output logic                     o_pslverr,
	input  wire logic [15:0]         i_fuse_data,
	output logic      [3:0]          o_fuse_addr,
	output logic                     o_fuse_rd,
	input  wire logic                i_core2_sel_b,
	input  wire logic                i_core3_sel_d,
	output actb_pkg::actb_ofs_t      o_core1_offset_value,
	output actb_pkg::actb_ofs_t      o_core2_offset_value,
	output actb_pkg::actb_ofs_t      o_core3_offset_value,
	output actb_pkg::actb_ofs_t      o_core4_offset_value,
	output actb_pkg::actb_ofs_t      o_core5_offset_value,
	output actb_pkg::actb_gain_t     o_core0_fine_gain_value,
	output actb_pkg::actb_gain_t     o_core1_fine_gain_value,
	output logic                     o_load_busy
);
	import actb_pkg::*;

	actb_fuse_if f ();

	// ----------------------------------------------------------------
	// Fuse loader and input selection
	// ----------------------------------------------------------------
	// Loader owns the bank until every fuse word has landed
	actb_fuse_loader actb_fuse_loader_i (
		.i_clk_sys   (i_clk_sys),
		.i_sys_rst   (i_sys_rst),
		.i_fuse_data (i_fuse_data),
		.o_fuse_addr (o_fuse_addr),
		.o_fuse_rd   (o_fuse_rd),
		.f           (f.loader)
	);

	actb_word_t trim_q [NUM_SLOTS];
	actb_word_t trim_d [NUM_SLOTS];

	// Cores 2 and 3 pick their stored offset by the sampled input
	actb_input_sel actb_input_sel_i (
		.i_clk_sys     (i_clk_sys),
		.i_sys_rst     (i_sys_rst),
		.i_ofs_a       (trim_q[SLOT_C2A][OFS_MSB:0]),
		.i_ofs_b       (trim_q[SLOT_C2B][OFS_MSB:0]),
		.i_ofs_c       (trim_q[SLOT_C3C][OFS_MSB:0]),
		.i_ofs_d       (trim_q[SLOT_C3D][OFS_MSB:0]),
		.i_core2_sel_b (i_core2_sel_b),
		.i_core3_sel_d (i_core3_sel_d),
		.o_core2_ofs   (o_core2_offset_value),
		.o_core3_ofs   (o_core3_offset_value)
	);

	// ----------------------------------------------------------------
	// APB slave
	// ----------------------------------------------------------------
	logic [4:0]  dec;
	logic        hit;
	logic [3:0]  slot;
	logic        acc;
	logic        wr_take;
	logic        pready_q, pready_d;
	logic        pslverr_q, pslverr_d;
	logic [31:0] prdata_q, prdata_d;
	logic        busy_q, busy_d;

	// Decode and the cycle in which a write lands
	always_comb begin
		dec     = actb_decode(i_paddr);
		hit     = dec[4];
		slot    = dec[3:0];
		acc     = i_psel && i_penable;
		wr_take = acc && pready_q && i_pwrite && hit;
	end

	// One wait state; stalled while fuse words are still loading
	always_comb begin
		pready_d  = 1'b0;
		pslverr_d = 1'b0;
		prdata_d  = RDATA_RST;
		busy_d    = f.busy;
		if (acc && !pready_q && !f.busy) begin
			pready_d  = 1'b1;
			pslverr_d = !hit;
			// (RULE12) read back stored word
			if (!i_pwrite && hit) begin
				prdata_d = {16'h0000, trim_q[slot]};
			end
		end
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			pready_q  <= 1'b0;
			pslverr_q <= 1'b0;
			prdata_q  <= RDATA_RST;
			busy_q    <= 1'b1;
		end else begin
			pready_q  <= pready_d;
			pslverr_q <= pslverr_d;
			prdata_q  <= prdata_d;
			busy_q    <= busy_d;
		end
	end

	assign o_pready    = pready_q;
	assign o_pslverr   = pslverr_q;
	assign o_prdata    = prdata_q;
	assign o_load_busy = busy_q;

	// ----------------------------------------------------------------
	// Trim storage
	// ----------------------------------------------------------------
	// Gain slots hold one byte whichever side writes them
	function automatic logic gain_slot(input logic [3:0] s);
		return (s == SLOT_G0) || (s == SLOT_G1);
	endfunction

	// Fuse load has priority; software cannot reach the bank then anyway
	always_comb begin
		for (int i = 0; i < NUM_SLOTS; i++) begin
			trim_d[i] = trim_q[i];
		end
		// (RULE9) fuse word into its slot
		if (f.load_vld) begin
			// Gain slots keep one byte from the fuses too
			if (gain_slot(f.load_slot)) begin
				trim_d[f.load_slot] = {8'h00, f.load_data[7:0]};
			end else begin
				trim_d[f.load_slot] = f.load_data;
			end
		end else if (wr_take) begin
			// (RULE7) gain registers keep one byte
			if (gain_slot(slot)) begin
				trim_d[slot] = {8'h00, i_pwdata[7:0]};
			end else begin
				// (RULE8) reserved bits stored as written
				trim_d[slot] = i_pwdata[15:0];
			end
		end
	end

	// Offset slots keep reserved bits 15:12 so a read returns what was written; gain slots keep bits 7:0 only
	generate
		for (genvar g = 0; g < NUM_SLOTS; g++) begin : g_trim
			always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					trim_q[g] <= TRIM_RST;
				end else begin
					trim_q[g] <= trim_d[g];
				end
			end
		end
	endgenerate

	// ----------------------------------------------------------------
	// Applied correction values
	// ----------------------------------------------------------------
	actb_ofs_t  c1_q, c1_d;
	actb_ofs_t  c4_q, c4_d;
	actb_ofs_t  c5_q, c5_d;
	actb_gain_t g0_q, g0_d;
	actb_gain_t g1_q, g1_d;

	// Offsets leave as plain unsigned fields, no sign extension
	always_comb begin
		// (RULE1) core 1 offset field
		c1_d = trim_q[SLOT_C1][OFS_MSB:0];
		// (RULE4) core 4 offset field
		c4_d = trim_q[SLOT_C4][OFS_MSB:0];
		// (RULE5) core 5 offset field
		c5_d = trim_q[SLOT_C5][OFS_MSB:0];
		// (RULE6) core 0 gain field
		g0_d = trim_q[SLOT_G0][GAIN_MSB:0];
		// (RULE7) core 1 gain field
		g1_d = trim_q[SLOT_G1][GAIN_MSB:0];
	end

	always_ff @(posedge i_clk_sys or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			c1_q <= 12'h000;
			c4_q <= 12'h000;
			c5_q <= 12'h000;
			g0_q <= 5'h00;
			g1_q <= 5'h00;
		end else begin
			c1_q <= c1_d;
			c4_q <= c4_d;
			c5_q <= c5_d;
			g0_q <= g0_d;
			g1_q <= g1_d;
		end
	end

	// (RULE10) unsigned field straight out
	assign o_core1_offset_value    = c1_q;
	assign o_core4_offset_value    = c4_q;
	assign o_core5_offset_value    = c5_q;
	assign o_core0_fine_gain_value = g0_q;
	assign o_core1_fine_gain_value = g1_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge i_clk_sys); endclocking
	default disable iff (i_sys_rst);

	sequence s_wr(logic [3:0] s);
		wr_take && slot == s;
	endsequence

	sequence s_rd;
		acc && !pready_q && !i_pwrite && hit && !f.busy;
	endsequence

	// First access cycle to an address that nothing answers
	sequence s_miss;
		acc && !pready_q && !hit && !f.busy;
	endsequence

	// Store edge, then one more register stage before an output moves

	core1_apply_a: assert property (s_wr(SLOT_C1) |=> ##1 // (RULE1)
		o_core1_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core1 offset not applied");

	core2_input_a_a: assert property (s_wr(SLOT_C2A) ##1 !i_core2_sel_b |=> // (RULE2)
		o_core2_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core2 input A offset not applied");

	core3_input_d_a: assert property (s_wr(SLOT_C3D) ##1 i_core3_sel_d |=> // (RULE3)
		o_core3_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core3 input D offset not applied");

	core4_apply_a: assert property (s_wr(SLOT_C4) |=> ##1 // (RULE4)
		o_core4_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core4 offset not applied");

	core5_apply_a: assert property (s_wr(SLOT_C5) |=> ##1 // (RULE5)
		o_core5_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core5 offset not applied");

	core0_fine_gain_trim_apply_a: assert property (s_wr(SLOT_G0) |=> ##1 // (RULE6)
		o_core0_fine_gain_value == 5'($past(i_pwdata, 2)))
		else $error("core0 gain not applied");

	core1_fine_gain_trim_separate_a: assert property (s_wr(SLOT_G1) |=> ##1 // (RULE7)
		o_core1_fine_gain_value == 5'($past(i_pwdata, 2)) && $stable(o_core0_fine_gain_value))
		else $error("core1 gain write not separate");

	fuse_load_a: assert property (f.load_vld && f.load_slot == SLOT_C4 |=> ##1 // (RULE9)
		o_core4_offset_value == 12'($past(f.load_data, 2)))
		else $error("fuse word not applied");

	load_stall_a: assert property (f.busy |=> !o_pready) // (RULE9)
		else $error("bus answered during fuse load");

	read_back_a: assert property (s_rd |=> // (RULE12)
		o_pready && o_prdata == {16'h0000, $past(trim_q[slot])})
		else $error("read data differs from stored word");

	core2_input_b_a: assert property (s_wr(SLOT_C2B) ##1 i_core2_sel_b |=> // (RULE2)
		o_core2_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core2 input B offset not applied");

	core3_input_c_a: assert property (s_wr(SLOT_C3C) ##1 !i_core3_sel_d |=> // (RULE3)
		o_core3_offset_value == 12'($past(i_pwdata, 2)))
		else $error("core3 input C offset not applied");

	refuse_err_a: assert property (s_miss |=> // (RULE12)
		o_pready && o_pslverr && o_prdata == RDATA_RST)
		else $error("unmapped access not refused");

	ready_pulse_a: assert property (o_pready |=> !o_pready) // (RULE12)
		else $error("ready held longer than one cycle");

	wr_store_a: assert property (s_wr(SLOT_C1) |=> // (RULE12)
		trim_q[SLOT_C1] == $past(i_pwdata[15:0]))
		else $error("written word not stored whole");

	fuse_core1_a: assert property (f.load_vld && f.load_slot == SLOT_C1 |=> ##1 // (RULE9)
		o_core1_offset_value == 12'($past(f.load_data, 2)))
		else $error("fuse word for core1 not applied");

	fuse_gain_a: assert property (f.load_vld && f.load_slot == SLOT_G1 |=> ##1 // (RULE9)
		o_core1_fine_gain_value == 5'($past(f.load_data, 2)))
		else $error("fuse word for core1 gain not applied");

	load_done_a: assert property (!f.busy |=> !f.busy) // (RULE9)
		else $error("fuse loader restarted without reset");

endmodule
`default_nettype wire

// file: verif/test_actb_trim_bank.sv
`timescale 1ns/1ps
`default_nettype none
module test_actb_trim_bank;
	import actb_pkg::*;

	// ----------------------------------------------------------------
	// Signals and bench state
	// ----------------------------------------------------------------
	logic        clk;
	logic        rst;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic [15:0] fuse_data;
	logic [3:0]  fuse_addr;
	logic        fuse_rd;
	logic        sel_b;
	logic        sel_d;
	actb_ofs_t   core1_offset_trim;
	actb_ofs_t   ofs2;
	actb_ofs_t   ofs3;
	actb_ofs_t   core4_offset_trim;
	actb_ofs_t   core5_offset_trim;
	actb_gain_t  core0_fine_gain_trim;
	actb_gain_t  core1_fine_gain_trim;
	logic        busy;
	int          errors;
	int          check_count;
	logic [15:0] fuse_rom [9];
	logic [15:0] mir      [9];
	logic [9:0]  idx      [9] = '{IDX_C1_OFS, IDX_C2A_OFS, IDX_C2B_OFS, IDX_C3C_OFS, IDX_C3D_OFS,
	                              IDX_C4_OFS, IDX_C5_OFS, IDX_G0_GAIN, IDX_G1_GAIN};
	logic [11:0] bad      [4] = '{12'hcc0, 12'hcc4, 12'hcca, 12'hd88};

	actb_trim_bank actb_trim_bank_i (
		.i_clk_sys(clk), .i_sys_rst(rst), .i_psel(psel), .i_penable(penable),
		.i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .o_prdata(prdata),
		.o_pready(pready), .o_pslverr(pslverr), .i_fuse_data(fuse_data),
		.o_fuse_addr(fuse_addr), .o_fuse_rd(fuse_rd), .i_core2_sel_b(sel_b),
		.i_core3_sel_d(sel_d), .o_core1_offset_value(core1_offset_trim), .o_core2_offset_value(ofs2),
		.o_core3_offset_value(ofs3), .o_core4_offset_value(core4_offset_trim),
		.o_core5_offset_value(core5_offset_trim), .o_core0_fine_gain_value(core0_fine_gain_trim),
		.o_core1_fine_gain_value(core1_fine_gain_trim), .o_load_busy(busy)
	);

	// Clock and watchdog, the whole run needs a few hundred cycles
	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end
	initial begin
		#(40 * 20000);
		errors++;
		end_sim;
	end

	// Fuse storage answers one cycle after each read pulse
	always @(posedge clk) begin
		if (fuse_rd === 1'b1) begin
			fuse_data <= fuse_rom[fuse_addr];
		end
	end

	// ----------------------------------------------------------------
	// Shared tasks
	// ----------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			errors++;
			$display("[ERR] %s expected %h seen %h", nm, exp, got);
		end
	endtask

	// offsets touched outside calibration
	// One APB transfer; holds the request until pready is sampled high
	task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
			output logic [31:0] r, output logic e);
		int n;
		@(posedge clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge clk);
		penable <= 1'b1;
		n = 0;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 100);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		chk("pready", 32'(pready), 32'h1);
	endtask

	task automatic read_all;
		logic [31:0] r;
		logic        e;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			apb({idx[s], 2'b00}, 1'b0, 32'h0, r, e);
			chk("readback", r, 32'(mir[s]));
			chk("read_err", 32'(e), 32'h0);
		end
	endtask

	// Applied values, both input selections for cores 2 and 3
	task automatic check_all;
		sel_b <= 1'b0;
		sel_d <= 1'b0;
		repeat (3) @(posedge clk);
		chk("core1_ofs", 32'(core1_offset_trim), 32'(mir[0][11:0]));
		chk("core2_ofs_a", 32'(ofs2), 32'(mir[1][11:0]));
		chk("core3_ofs_c", 32'(ofs3), 32'(mir[3][11:0]));
		chk("core4_ofs", 32'(core4_offset_trim), 32'(mir[5][11:0]));
		chk("core5_ofs", 32'(core5_offset_trim), 32'(mir[6][11:0]));
		chk("core0_gain", 32'(core0_fine_gain_trim), 32'(mir[7][4:0]));
		chk("core1_gain", 32'(core1_fine_gain_trim), 32'(mir[8][4:0]));
		sel_b <= 1'b1;
		sel_d <= 1'b1;
		repeat (3) @(posedge clk);
		chk("core2_ofs_b", 32'(ofs2), 32'(mir[2][11:0]));
		chk("core3_ofs_d", 32'(ofs3), 32'(mir[4][11:0]));
		sel_b <= 1'b0;
		sel_d <= 1'b0;
	endtask

	// ----------------------------------------------------------------
	// Scenarios
	// ----------------------------------------------------------------
	// Reset, then a read that stalls while fuse words load
	task automatic t_reset;
		logic [31:0] r;
		logic        e;
		int          n;
		rst <= 1'b1;
		repeat (5) @(posedge clk);
		chk("busy_in_reset", 32'(busy), 32'h1);
		chk("ofs_in_reset", 32'(core1_offset_trim), 32'h0);
		rst <= 1'b0;
		for (int s = 0; s < NUM_SLOTS; s++) mir[s] = fuse_rom[s];
		apb({idx[0], 2'b00}, 1'b0, 32'h0, r, e);
		chk("stalled_read", r, 32'(fuse_rom[0]));
		n = 0;
		while (busy !== 1'b0 && n < 100) begin
			@(posedge clk);
			n++;
		end
		chk("busy_end", 32'(busy), 32'h0);
		check_all;
		read_all;
	endtask

	// Write every register twice, offsets stepping down from 0x0fff and gains 0x15/0x1f, then zero
	task automatic t_write;
		logic [31:0] r;
		logic        e;
		for (int p = 0; p < 2; p++) begin
			// Pass 0 writes while inputs A and C are sampled, pass 1 B and D
			sel_b <= p[0];
			sel_d <= p[0];
			for (int s = 0; s < NUM_SLOTS; s++) begin
				mir[s] = (p == 1) ? 16'h0 : (s < 7) ? 16'h0fff - 16'(s) * 16'h0123 : 16'h0015 + 16'(s - 7) * 16'h000a;
				// Reserved upper bits stay zero
				apb({idx[s], 2'b00}, 1'b1, 32'(mir[s]), r, e);
				chk("write_err", 32'(e), 32'h0);
			end
			check_all;
			read_all;
		end
	endtask

	// Unmapped and misaligned places refuse and leave storage alone
	task automatic t_refuse;
		logic [31:0] r;
		logic        e;
		for (int i = 0; i < 4; i++) begin
			apb(bad[i], 1'b1, 32'h0000_0abc, r, e);
			chk("bad_write_err", 32'(e), 32'h1);
			apb(bad[i], 1'b0, 32'h0, r, e);
			chk("bad_read_err", 32'(e), 32'h1);
			chk("bad_read_data", r, 32'h0);
		end
		read_all;
	endtask

	task automatic end_sim;
		$display("checks %0d errors %0d", check_count, errors);
		if (errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask

	// Main sequence, with a second reset after software changes
	initial begin
		rst       = 1'b1;
		psel      = 1'b0;
		penable   = 1'b0;
		pwrite    = 1'b0;
		paddr     = 12'h000;
		pwdata    = 32'h0;
		fuse_data = 16'h0;
		sel_b     = 1'b0;
		sel_d     = 1'b0;
		errors      = 0;
		check_count = 0;
		for (int s = 0; s < NUM_SLOTS; s++) begin
			fuse_rom[s] = (s < 7) ? 16'h08a5 + 16'(s) * 16'h0111 : 16'h0017 - 16'(s - 7) * 16'h000e;
		end
		t_reset;
		t_write;
		t_refuse;
		t_reset;
		end_sim;
	end

endmodule
`default_nettype wire
